// >>> verilog/icac_map.svh
`ifndef ICAC_MAP_SVH
`define ICAC_MAP_SVH

// Register indices held by the address pointer
`define ICAC_REG_CHAN_CFG      8'h10
`define ICAC_REG_CFG2          8'h11
`define ICAC_REG_VOLT_ID       8'h12
`define ICAC_REG_VALUE_BASE    8'h20
`define ICAC_REG_VALUE_LAST    8'h29

// Field positions in input_channel_configuration
`define ICAC_CFG_AUX_A_BIT     0
`define ICAC_CFG_AUX_B_BIT     1
`define ICAC_CFG_DIODE2_BIT    2
`define ICAC_CFG_RANGE_5V_BIT  3
`define ICAC_CFG_EXT_IRQ_LINE_0_BIT      4
`define ICAC_CFG_EXT_IRQ_LINE_1_BIT      5
`define ICAC_CFG_EXT_IRQ_LINE_2_BIT      6
`define ICAC_CFG_IRQ_MODE_BIT  7
// Field positions in the second general configuration register
`define ICAC_CFG2_IRQ3_BIT     6
`define ICAC_CFG2_IRQ4_BIT     7

// Reset values
`define ICAC_CHAN_CFG_RESET    8'h00
`define ICAC_CFG2_RESET        8'h00

// Timing
`define ICAC_CLK_MHZ           100
`define ICAC_SLOT_TIME_US      748
`define ICAC_DIODE_TIME_US     9600
`define ICAC_DIODE_AVG_COUNT   16
`define ICAC_LAST_CHAN         4'h9

`endif

// >>> verilog/icac_pkg.sv
package icac_pkg;

    typedef enum logic [3:0] {
        CH_DIODE1      = 4'h0,
        CH_SUPPLY_12V  = 4'h1,
        CH_SUPPLY_5V   = 4'h2,
        CH_FIRST_CORE  = 4'h3,
        CH_INT_SUPPLY  = 4'h4,
        CH_AUX_A       = 4'h5,
        CH_AUX_B       = 4'h6,
        CH_SUPPLY_2V5  = 4'h7,
        CH_SECOND_CORE = 4'h8,
        CH_DIODE2      = 4'h9
    } icac_chan_type;

    // Gray along idle -> wait -> store
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_WAIT  = 2'h1,
        ST_STORE = 2'h3
    } icac_state_type;

endpackage

// >>> verilog/icac_value_ram.sv
module icac_value_ram (
    input  wire logic       clk_in,
    input  wire logic       we_in,
    input  wire logic [3:0] waddr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic [3:0] raddr_in,
    output logic      [7:0] rdata_out
);
    logic [7:0] mem [0:15];

    // Whole byte written in one edge, so a read never sees half a result
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= mem[raddr_in];
    end
endmodule // icac_value_ram

// >>> verilog/icac_sequencer.sv
// Summary of operation
// - Dedicated diode and four analog channels convert regardless of configuration.
// - Bits 0 and 1 pick tachometer (0) or analog input (1) per pin.
// - Bit 2 picks 2.5 V and second core supply (0) or second diode (1).
// - Bit 3 picks internal supply range, 3.3 V (0) or 5 V (1).
// - Bit 7 turns the five voltage-ID pins into interrupt inputs.
// - With bit 7 set, bits 4 to 6 enable interrupt lines 0 to 2.
// - Lines 3 and 4 are enabled by second configuration register bits 6, 7.
// - Channel configuration resets to all zeros.
// - One shared converter yields 8-bit codes; diode codes are sign-extended when averaged.
// - Supply scaling puts nominal voltage at code 192; range select drives it.
// - One non-diode channel converts every 748 us while running.
// - Diode result averages 16 conversions over nominally 9.6 ms.
`include "icac_map.svh"

module icac_sequencer #(
    parameter int SLOT_CYCLES  = `ICAC_SLOT_TIME_US * `ICAC_CLK_MHZ,
    parameter int DIODE_CYCLES = `ICAC_DIODE_TIME_US * `ICAC_CLK_MHZ
) (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       ptr_wr_in,
    input  wire logic       data_wr_in,
    input  wire logic [7:0] bus_data_in,
    output logic      [7:0] rd_data_out,
    input  wire logic       converter_run_in,
    input  wire logic       adc_done_in,
    input  wire logic [7:0] adc_result_in,
    output logic            adc_start_out,
    output logic      [3:0] adc_channel_out,
    output logic            supply_5v_range_out,
    output logic            tach_input_a_en_out,
    output logic            tach_input_b_en_out,
    output logic            second_diode_mode_out,
    input  wire logic [4:0] volt_id_line_in,
    output logic      [4:0] volt_id_out,
    output logic            volt_id_irq_mode_out,
    output logic      [4:0] ext_irq_enable_out,
    output logic      [4:0] ext_irq_event_out
);
    localparam logic [19:0] SLOT_LEN  = 20'(SLOT_CYCLES);
    localparam logic [19:0] DIODE_LEN = 20'(DIODE_CYCLES / `ICAC_DIODE_AVG_COUNT);
    localparam logic [3:0]  LAST_SUB  = 4'(`ICAC_DIODE_AVG_COUNT - 1);

    function automatic logic is_diode(input logic [3:0] ch);
        is_diode = (ch == icac_pkg::CH_DIODE1) || (ch == icac_pkg::CH_DIODE2);
    endfunction

    function automatic logic chan_enabled(input logic [3:0] ch, input logic [7:0] c);
        case (ch)
            icac_pkg::CH_DIODE1, icac_pkg::CH_SUPPLY_12V, icac_pkg::CH_SUPPLY_5V,
            icac_pkg::CH_FIRST_CORE, icac_pkg::CH_INT_SUPPLY: chan_enabled = 1'b1;
            icac_pkg::CH_AUX_A:       chan_enabled = c[`ICAC_CFG_AUX_A_BIT];
            icac_pkg::CH_AUX_B:       chan_enabled = c[`ICAC_CFG_AUX_B_BIT];
            icac_pkg::CH_SUPPLY_2V5,
            icac_pkg::CH_SECOND_CORE: chan_enabled = !c[`ICAC_CFG_DIODE2_BIT];
            icac_pkg::CH_DIODE2:      chan_enabled = c[`ICAC_CFG_DIODE2_BIT];
            default:                  chan_enabled = 1'b0;
        endcase
    endfunction

    function automatic logic [3:0] next_chan(input logic [3:0] cur, input logic [7:0] c);
        logic [3:0] cand;
        logic       found;
        cand      = cur;
        found     = 1'b0;
        next_chan = cur;
        for (int i = 0; i < 10; i++) begin
            cand = (cand == `ICAC_LAST_CHAN) ? 4'h0 : cand + 4'h1;
            if (!found && chan_enabled(cand, c)) begin
                next_chan = cand;
                found     = 1'b1;
            end
        end
    endfunction

    // Register file
    logic [7:0] pointer;
    logic [7:0] chan_cfg;
    logic [7:0] cfg2;
    logic [7:0] ram_rdata;
    logic [4:0] volt_id_stable;

    wire        cfg_sel   = (pointer == `ICAC_REG_CHAN_CFG);
    wire        cfg2_sel  = (pointer == `ICAC_REG_CFG2);
    wire        vid_sel   = (pointer == `ICAC_REG_VOLT_ID);
    wire        value_sel = (pointer >= `ICAC_REG_VALUE_BASE) &&
                            (pointer <= `ICAC_REG_VALUE_LAST);
    wire [7:0]  value_off = pointer - `ICAC_REG_VALUE_BASE;
    wire [7:0]  next_rd   = cfg_sel   ? chan_cfg :
                            cfg2_sel  ? cfg2 :
                            vid_sel   ? {3'h0, volt_id_stable} :
                            value_sel ? ram_rdata : 8'h00;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pointer     <= 8'h00;
            chan_cfg    <= `ICAC_CHAN_CFG_RESET;
            cfg2        <= `ICAC_CFG2_RESET;
            rd_data_out <= 8'h00;
        end else begin
            if (ptr_wr_in) begin
                pointer <= bus_data_in;
            end
            if (data_wr_in && cfg_sel) begin
                chan_cfg <= bus_data_in;
            end
            if (data_wr_in && cfg2_sel) begin
                cfg2 <= bus_data_in;
            end
            rd_data_out <= next_rd;
        end
    end

    // Pin function selects
    wire [4:0] next_irq_en = {cfg2[`ICAC_CFG2_IRQ4_BIT], cfg2[`ICAC_CFG2_IRQ3_BIT],
                              chan_cfg[`ICAC_CFG_EXT_IRQ_LINE_2_BIT], chan_cfg[`ICAC_CFG_EXT_IRQ_LINE_1_BIT],
                              chan_cfg[`ICAC_CFG_EXT_IRQ_LINE_0_BIT]} &
                             {5{chan_cfg[`ICAC_CFG_IRQ_MODE_BIT]}};

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tach_input_a_en_out   <= 1'b1;
            tach_input_b_en_out   <= 1'b1;
            second_diode_mode_out <= 1'b0;
            supply_5v_range_out   <= 1'b0;
            volt_id_irq_mode_out  <= 1'b0;
            ext_irq_enable_out    <= 5'h00;
        end else begin
            tach_input_a_en_out   <= !chan_cfg[`ICAC_CFG_AUX_A_BIT];
            tach_input_b_en_out   <= !chan_cfg[`ICAC_CFG_AUX_B_BIT];
            second_diode_mode_out <= chan_cfg[`ICAC_CFG_DIODE2_BIT];
            supply_5v_range_out   <= chan_cfg[`ICAC_CFG_RANGE_5V_BIT];
            volt_id_irq_mode_out  <= chan_cfg[`ICAC_CFG_IRQ_MODE_BIT];
            ext_irq_enable_out    <= next_irq_en;
        end
    end

    // Voltage-ID pins: three stages, a change counts once stages two and three agree
    logic [4:0] vid_s1;
    logic [4:0] vid_s2;
    logic [4:0] vid_s3;
    wire  [4:0] vid_agree   = ~(vid_s2 ^ vid_s3);
    wire  [4:0] next_stable = (vid_agree & vid_s3) | (~vid_agree & volt_id_stable);
    // Interrupt inputs taken as active low: event on a falling settled level
    wire  [4:0] next_event  = volt_id_stable & ~next_stable & ext_irq_enable_out;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            vid_s1            <= 5'h00;
            vid_s2            <= 5'h00;
            vid_s3            <= 5'h00;
            volt_id_stable    <= 5'h00;
            volt_id_out       <= 5'h00;
            ext_irq_event_out <= 5'h00;
        end else begin
            vid_s1            <= volt_id_line_in;
            vid_s2            <= vid_s1;
            vid_s3            <= vid_s2;
            volt_id_stable    <= next_stable;
            volt_id_out       <= next_stable;
            ext_irq_event_out <= next_event;
        end
    end

    // Conversion sequencer
    icac_pkg::icac_state_type state;
    logic [3:0]  cur_chan;
    logic [7:0]  cfg_active;
    logic [19:0] slot_cnt;
    logic [19:0] slot_len;
    logic [3:0]  sub_cnt;
    logic [11:0] acc;
    logic [7:0]  result;
    logic        ram_we;
    logic [3:0]  ram_waddr;
    logic [7:0]  ram_wdata;

    wire        slot_done = (slot_cnt == slot_len - 20'h0_0001);
    wire        start_now = slot_done && converter_run_in && (state == icac_pkg::ST_IDLE);
    // Snapshot at slot start, so a write mid-conversion waits for the next slot
    wire [3:0]  sel_chan  = chan_enabled(cur_chan, chan_cfg) ? cur_chan
                                                              : next_chan(cur_chan, chan_cfg);
    wire        cur_diode = is_diode(cur_chan);
    wire [11:0] next_acc  = acc + {{4{result[7]}}, result};
    wire        last_sub  = (sub_cnt == LAST_SUB);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            slot_cnt <= 20'h0_0000;
        end else if (!converter_run_in || slot_done) begin
            slot_cnt <= 20'h0_0000;
        end else begin
            slot_cnt <= slot_cnt + 20'h0_0001;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state           <= icac_pkg::ST_IDLE;
            cur_chan        <= 4'h0;
            cfg_active      <= `ICAC_CHAN_CFG_RESET;
            slot_len        <= SLOT_LEN;
            sub_cnt         <= 4'h0;
            acc             <= 12'h000;
            result          <= 8'h00;
            adc_start_out   <= 1'b0;
            adc_channel_out <= 4'h0;
            ram_we          <= 1'b0;
            ram_waddr       <= 4'h0;
            ram_wdata       <= 8'h00;
        end else begin
            adc_start_out <= 1'b0;
            ram_we        <= 1'b0;
            case (state)
                icac_pkg::ST_IDLE: begin
                    if (start_now) begin
                        cfg_active      <= chan_cfg;
                        cur_chan        <= sel_chan;
                        adc_channel_out <= sel_chan;
                        adc_start_out   <= 1'b1;
                        slot_len        <= is_diode(sel_chan) ? DIODE_LEN : SLOT_LEN;
                        state           <= icac_pkg::ST_WAIT;
                        // Diode run cut short by a config change starts over, never mixes
                        if (sel_chan != cur_chan) begin
                            sub_cnt <= 4'h0;
                            acc     <= 12'h000;
                        end
                    end
                end
                icac_pkg::ST_WAIT: begin
                    if (adc_done_in) begin
                        result <= adc_result_in;
                        state  <= icac_pkg::ST_STORE;
                    end
                end
                icac_pkg::ST_STORE: begin
                    state <= icac_pkg::ST_IDLE;
                    if (cur_diode && !last_sub) begin
                        acc     <= next_acc;
                        sub_cnt <= sub_cnt + 4'h1;
                    end else begin
                        ram_we    <= 1'b1;
                        ram_waddr <= cur_chan;
                        ram_wdata <= cur_diode ? next_acc[11:4] : result;
                        acc       <= 12'h000;
                        sub_cnt   <= 4'h0;
                        cur_chan  <= next_chan(cur_chan, cfg_active);
                    end
                end
                default: begin
                    state <= icac_pkg::ST_IDLE;
                end
            endcase
        end
    end

    icac_value_ram u_value_ram (
        .clk_in    (clk_in),
        .we_in     (ram_we),
        .waddr_in  (ram_waddr),
        .wdata_in  (ram_wdata),
        .raddr_in  (value_off[3:0]),
        .rdata_out (ram_rdata)
    );

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    a_cfg_write_lands: assert property (
        data_wr_in && cfg_sel |=> chan_cfg == $past(bus_data_in))
        else $error("channel configuration write lost");
    a_tach_select: assert property (
        ##1 (tach_input_a_en_out == !$past(chan_cfg[0])) &&
            (tach_input_b_en_out == !$past(chan_cfg[1])))
        else $error("tachometer select wrong");
    a_diode2_pair: assert property (
        ##1 second_diode_mode_out == $past(chan_cfg[2]))
        else $error("second diode select wrong");
    a_supply_range: assert property (
        ##1 supply_5v_range_out == $past(chan_cfg[3]))
        else $error("supply range select wrong");
    a_irq_mode_low: assert property (
        !chan_cfg[7] |=> ext_irq_enable_out == 5'h00 && !volt_id_irq_mode_out)
        else $error("interrupt enables active without interrupt mode");
    a_irq_upper_lines: assert property (
        chan_cfg[7] |=> ext_irq_enable_out[4:3] == $past(cfg2[7:6]))
        else $error("upper interrupt enables wrong");
    a_start_enabled: assert property (
        adc_start_out |-> chan_enabled(adc_channel_out, cfg_active))
        else $error("disabled channel converted");
    a_start_on_slot: assert property (
        start_now |=> adc_start_out ##1 !adc_start_out)
        else $error("slot start missed");
    a_diode_sixteen: assert property (
        ram_we && is_diode(ram_waddr) |-> $past(sub_cnt) == LAST_SUB)
        else $error("diode stored before sixteen conversions");
    a_single_write: assert property (
        ram_we |=> !ram_we)
        else $error("value written more than once");

    c_diode_store: cover property (ram_we && ram_waddr == icac_pkg::CH_DIODE2);
    c_aux_store:   cover property (ram_we && ram_waddr == icac_pkg::CH_AUX_A);
    c_irq_event:   cover property (ext_irq_event_out != 5'h00);

endmodule // icac_sequencer

// >>> testbench/icac_adc_model.sv
module icac_adc_model (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       slow_in,
    input  wire logic       start_in,
    input  wire logic [3:0] channel_in,
    output logic            done_out,
    output logic      [7:0] result_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int         wait_cnt;
    logic [3:0] chan;
    logic       alt;
    logic [7:0] next_result;
    // Diode codes straddle the sign boundary so zero extension shows up
    assign next_result = (chan == 4'h0 || chan == 4'h9) ? (alt ? 8'h80 : 8'h7F)
                                                         : {4'hC, chan};
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_cnt <= 0;
            chan <= 4'h0;
            alt <= 1'b0;
            done_out <= 1'b0;
            result_out <= 8'h00;
        end else begin
            done_out <= 1'b0;
            // Not valid outside done, so never left showing the last code
            result_out <= ~result_out;
            if (start_in) begin
                wait_cnt <= slow_in ? 12 : 2;
                chan <= channel_in;
            end else if (wait_cnt == 1) begin
                done_out <= 1'b1;
                result_out <= next_result;
                alt <= !alt;
                wait_cnt <= 0;
            end else if (wait_cnt > 1) begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule // icac_adc_model

// >>> testbench/input_channel_config_adc_sequencer_tb_top.sv
module input_channel_config_adc_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, reset_n, ptr_wr, data_wr, run, slow, done, start;
    logic       range5, tach_a, tach_b, diode2, irq_mode, prev_ok, len_ok;
    logic [7:0] bus_data, rd_data, result, cur_cfg, d;
    logic [3:0] chan, prev_ch;
    logic [4:0] vid_in, vid_out, irq_en, irq_ev, ev_seen;
    int         n_fail, checks_done, cycles, gap, run_len;
    logic [7:0] pats [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'hF0, 8'h70};

    icac_sequencer #(.SLOT_CYCLES(40), .DIODE_CYCLES(320)) i_icac_sequencer (
        .clk_in(clk), .reset_n_in(reset_n), .ptr_wr_in(ptr_wr), .data_wr_in(data_wr),
        .bus_data_in(bus_data), .rd_data_out(rd_data), .converter_run_in(run),
        .adc_done_in(done), .adc_result_in(result), .adc_start_out(start),
        .adc_channel_out(chan), .supply_5v_range_out(range5),
        .tach_input_a_en_out(tach_a), .tach_input_b_en_out(tach_b),
        .second_diode_mode_out(diode2), .volt_id_line_in(vid_in), .volt_id_out(vid_out),
        .volt_id_irq_mode_out(irq_mode), .ext_irq_enable_out(irq_en),
        .ext_irq_event_out(irq_ev));
    icac_adc_model i_icac_adc_model (
        .clk_in(clk), .reset_n_in(reset_n), .slow_in(slow), .start_in(start),
        .channel_in(chan), .done_out(done), .result_out(result));

    always #5 clk = ~clk;

    function automatic logic chan_on(input logic [3:0] c, input logic [7:0] cfg);
        case (c)
            4'h5: return cfg[0];
            4'h6: return cfg[1];
            4'h7, 4'h8: return !cfg[2];
            4'h9: return cfg[2];
            default: return c < 4'h5;
        endcase
    endfunction
    function automatic logic [3:0] next_on(input logic [3:0] c, input logic [7:0] cfg);
        logic [3:0] n;
        n = c;
        do n = (n == 4'h9) ? 4'h0 : n + 4'h1; while (!chan_on(n, cfg));
        return n;
    endfunction

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Pointer byte always goes first, as the host protocol demands
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
        @(posedge clk);
        ptr_wr <= 1'b1;
        bus_data <= idx;
        @(posedge clk);
        ptr_wr <= 1'b0;
        data_wr <= 1'b1;
        bus_data <= val;
        @(posedge clk);
        data_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] val);
        @(posedge clk);
        ptr_wr <= 1'b1;
        bus_data <= idx;
        @(posedge clk);
        ptr_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        val = rd_data;
    endtask
    task automatic conv_round(input logic [7:0] cfg, input logic slow_v);
        logic [7:0] v;
        wr_reg(8'h10, cfg);
        cur_cfg = cfg;
        slow <= slow_v;
        run <= 1'b1;
        repeat (1300) @(posedge clk);
        run <= 1'b0;
        repeat (40) @(posedge clk);
        for (int c = 0; c < 10; c++) if (chan_on(4'(c), cfg)) begin
            rd_reg(8'(8'h20 + c), v);
            chk("value", (c == 0 || c == 9) ? 8'hFF : 8'(8'hC0 + c), v);
        end
    endtask

    // Sequence monitor: order, diode run length and start-to-start spacing
    always @(posedge clk) begin
        gap++;
        ev_seen |= irq_ev;
        if (!run) begin
            prev_ok = 1'b0;
        end else if (start) begin
            chk("chan_enabled", 8'h01, {7'h00, chan_on(chan, cur_cfg)});
            if (prev_ok) chk("slot_gap", (prev_ch == 4'h0 || prev_ch == 4'h9) ? 8'h14 : 8'h28,
                             8'(gap));
            if (!prev_ok || chan != prev_ch) begin
                if (prev_ok) chk("next_chan", {4'h0, next_on(prev_ch, cur_cfg)},
                                 {4'h0, chan});
                if (prev_ok && len_ok && (prev_ch == 4'h0 || prev_ch == 4'h9))
                    chk("diode_runs", 8'h10, 8'(run_len));
                len_ok = prev_ok;
                run_len = 1;
            end else begin
                run_len++;
            end
            prev_ch = chan;
            prev_ok = 1'b1;
            gap = 0;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        clk = 0;
        reset_n = 0;
        ptr_wr = 0;
        data_wr = 0;
        bus_data = 8'h00;
        run = 0;
        slow = 0;
        vid_in = 5'h1F;
        cur_cfg = 8'h00;
        n_fail = 0;
        checks_done = 0;
        cycles = 0;
        gap = 0;
        prev_ok = 0;
        len_ok = 0;
        run_len = 0;
        prev_ch = 4'h0;
        ev_seen = 5'h00;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("reset_pins", 8'h0C, {3'h0, range5, tach_a, tach_b, diode2, irq_mode});
        chk("reset_irq_en", 8'h00, {3'h0, irq_en});
        rd_reg(8'h10, d);
        chk("cfg_reset", 8'h00, d);
        foreach (pats[i]) begin
            wr_reg(8'h10, pats[i]);
            chk("cfg_pins", {3'h0, pats[i][3], !pats[i][0], !pats[i][1], pats[i][2], pats[i][7]},
                {3'h0, range5, tach_a, tach_b, diode2, irq_mode});
            chk("irq_en", {5'h00, pats[i][6:4] & {3{pats[i][7]}}}, {3'h0, irq_en});
            rd_reg(8'h10, d);
            chk("cfg_read", pats[i], d);
        end
        wr_reg(8'h11, 8'hC0);
        chk("irq_en_off", 8'h00, {3'h0, irq_en});
        wr_reg(8'h10, 8'hF0);
        chk("irq_en_all", 8'h1F, {3'h0, irq_en});
        wr_reg(8'h30, 8'h55);
        rd_reg(8'h30, d);
        chk("unmapped", 8'h00, d);
        wr_reg(8'h10, 8'h90);
        wr_reg(8'h11, 8'h80);
        ev_seen = 5'h00;
        vid_in <= 5'h00;
        repeat (10) @(posedge clk);
        #1;
        chk("irq_events", 8'h11, {3'h0, ev_seen});
        chk("volt_id", 8'h00, {3'h0, vid_out});
        vid_in <= 5'h1F;
        wr_reg(8'h10, 8'h10);
        repeat (10) @(posedge clk);
        rd_reg(8'h12, d);
        chk("vid_read", 8'h1F, d);
        ev_seen = 5'h00;
        vid_in <= 5'h00;
        repeat (10) @(posedge clk);
        #1;
        chk("no_events", 8'h00, {3'h0, ev_seen});
        conv_round(8'h00, 1'b0);
        conv_round(8'h07, 1'b1);
        results();
    end
endmodule // input_channel_config_adc_sequencer_tb_top
